// >>> mcs_cfg_snapshot.sv
// Notes on behaviour
// - Pre-bias start only with input slew inside its positive and negative limits.
// - Output slew must also sit inside its own signed limits for pre-bias.
// - Filter byte: 0 output voltage, 1 output current, 2 feed-forward.
// - Snapshot command is read-only and returns a fixed 32-byte record.
// - Input loss while running stores the snapshot with no host command.
// - Commanded off after ramp, then input loss: all bytes FF but counter.
// - Top field of the snapshot counts shutdowns in operation; the code also counts input loss after a commanded off.
// - Snapshot keeps the previous cycle's eight status bytes and status word.
// - Snapshot keeps the previous power cycle duration in seconds.
// - Temperature 1 from the selected sensor, temperature 2 from the other.
// - Low four fields hold duty, load, output and input from normal running.
// - Below threshold 1 the first extra dead time, 0 to 255 ns, applies.
// - Below threshold 2 an independent second extra dead time applies.
// - Each dead time threshold is a signed integer byte in degrees.
// - Extra dead time ends only when temperature rises above its hysteresis.
// - Reference correction starts at a signed integer degree threshold.
// - Above it, add slope times excess degrees over 256, slope signed Q8.
// - Sensor select 0 is internal, 1 external; it orders the two temperatures.
`timescale 1ns/1ps
module mcs_cfg_snapshot #(
   parameter int unsigned SEC_CYCLES = mcs_pkg::SEC_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Management command port
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [63:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_err,
   output logic [5:0] rsp_len,
   output logic [255:0] rsp_data,
   // Stored compensation settings
   input wire logic cfg_load,
   input wire mcs_pkg::mcs_comp_s cfg_comp,
   // Converter core
   input wire logic conv_run,
   input wire logic vin_present_pin,
   input wire logic temp_sel,
   input wire logic [15:0] vin_slew,
   input wire logic [15:0] vout_slew,
   input wire logic [7:0] temp_c,
   input wire mcs_pkg::mcs_live_s live,
   // Results
   output logic prebias_ok,
   output mcs_pkg::mcs_loop_e loop_sel,
   output logic [8:0] deadtime_add_ns,
   output logic [15:0] ref_dac_corr,
   output logic snap_commit
);
   import mcs_pkg::*;

   typedef struct packed {
      mcs_slew_s slew;
      mcs_loop_e filt;
      mcs_comp_s comp;
      mcs_snap_s snap;
      logic vin_prev;
      logic run_prev;
      logic off_ramp;
      logic [31:0] sec_cnt;
      logic [15:0] op_secs;
      logic [15:0] old_duty;
      logic [15:0] old_iload;
      logic [15:0] old_vout;
      logic [15:0] old_vin;
      logic prebias;
      logic [8:0] dt_add;
      logic [15:0] dac_corr;
      logic commit;
      logic rsp_valid;
      logic rsp_err;
      logic [5:0] rsp_len;
      logic [255:0] rsp_data;
   } mcs_top_s;

   mcs_top_s q;
   mcs_top_s d;
   logic vin_ok;
   logic act1;
   logic act2;
   logic loss;
   logic sec_tick;

   function automatic logic in_win(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction : in_win

   function automatic logic [15:0] ref_corr(input logic [7:0] t,
                                            input logic [7:0] thr,
                                            input logic [7:0] slope);
      logic signed [8:0] dt;
      logic signed [17:0] p;
      dt = 9'($signed(t)) - 9'($signed(thr));
      p = 18'(dt) * 18'($signed(slope));
      if (dt > 0) begin
         return 16'(p >>> 8);
      end
      return 16'h0000;
   endfunction : ref_corr

   mcs_sync2 u_vin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(vin_present_pin),
      .dout(vin_ok)
   );

   mcs_dt_hyst u_dt1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .temp(temp_c),
      .thr(q.comp.dt_thr1),
      .hys(q.comp.dt_hys1),
      .active(act1)
   );

   mcs_dt_hyst u_dt2 (
      .clk(clk),
      .sys_rst(sys_rst),
      .temp(temp_c),
      .thr(q.comp.dt_thr2),
      .hys(q.comp.dt_hys2),
      .active(act2)
   );

   assign loss = q.vin_prev && !vin_ok;
   assign sec_tick = vin_ok && (q.sec_cnt == 32'(SEC_CYCLES - 1));

   always_comb begin
      d = q;
      d.vin_prev = vin_ok;
      d.run_prev = conv_run;
      d.commit = 1'b0;
      d.rsp_valid = 1'b0;
      d.rsp_err = 1'b0;

      d.prebias = in_win(vin_slew, q.slew.vin_neg, q.slew.vin_pos)
         && in_win(vout_slew, q.slew.vout_neg, q.slew.vout_pos);

      // Threshold compare and hysteresis live in the two units
      d.dt_add = {1'b0, act1 ? q.comp.dt_add1 : 8'h00}
         + {1'b0, act2 ? q.comp.dt_add2 : 8'h00};

      d.dac_corr = ref_corr(temp_c, q.comp.ref_thr,
         q.comp.ref_slope);

      if (cmd_wr) begin
         d.rsp_valid = 1'b1;
         case (cmd_code)
            CMD_SLEW: d.slew = cmd_wdata;
            CMD_FILT: begin
               if (cmd_wdata[7:0] <= 8'h02) begin
                  d.filt = mcs_loop_e'(cmd_wdata[7:0]);
               end else begin
                  d.rsp_err = 1'b1;
               end
            end
            default: d.rsp_err = 1'b1;
         endcase
      end else if (cmd_rd) begin
         d.rsp_valid = 1'b1;
         d.rsp_data = '0;
         case (cmd_code)
            CMD_SLEW: begin
               d.rsp_len = LEN_SLEW;
               d.rsp_data[63:0] = q.slew;
            end
            CMD_FILT: begin
               d.rsp_len = LEN_FILT;
               d.rsp_data[7:0] = q.filt;
            end
            CMD_SNAP: begin
               d.rsp_len = LEN_SNAP;
               d.rsp_data = q.snap;
            end
            CMD_COMP: begin
               d.rsp_len = LEN_COMP;
               d.rsp_data[63:0] = q.comp;
            end
            default: begin
               d.rsp_len = LEN_NONE;
               d.rsp_err = 1'b1;
            end
         endcase
      end

      if (cfg_load) begin
         d.comp = cfg_comp;
      end

      // Power cycle timer restarts when input returns
      if (vin_ok && !q.vin_prev) begin
         d.sec_cnt = '0;
         d.op_secs = '0;
      end else if (sec_tick) begin
         d.sec_cnt = '0;
         if (q.op_secs != 16'hFFFF) begin
            d.op_secs = q.op_secs + 16'h0001;
         end
      end else if (vin_ok) begin
         d.sec_cnt = q.sec_cnt + 32'h0000_0001;
      end

      // Readings from normal running, refreshed once a second
      if (sec_tick && conv_run) begin
         d.old_duty = live.duty;
         d.old_iload = live.iload;
         d.old_vout = live.vout;
         d.old_vin = live.vin;
      end

      // Track a ramp that ended in a commanded off
      if (conv_run && !q.run_prev) begin
         d.off_ramp = 1'b0;
      end else if (!conv_run && q.run_prev && vin_ok) begin
         d.off_ramp = 1'b1;
      end

      if (loss && conv_run) begin
         d.commit = 1'b1;
         d.snap.cycles = q.snap.cycles + 16'h0001;
         d.snap.status = live.status;
         d.snap.op_time = q.op_secs;
         d.snap.temp1 = temp_sel ? live.temp_ext : live.temp_int;
         d.snap.temp2 = temp_sel ? live.temp_int : live.temp_ext;
         d.snap.iload = live.iload;
         d.snap.vout = live.vout;
         d.snap.vin = live.vin;
         d.snap.duty_old = q.old_duty;
         d.snap.iload_old = q.old_iload;
         d.snap.vout_old = q.old_vout;
         d.snap.vin_old = q.old_vin;
      end else if (loss && q.off_ramp) begin
         d.commit = 1'b1;
         d.off_ramp = 1'b0;
         d.snap = SNAP_ERASED;
         d.snap.cycles = q.snap.cycles + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.slew <= SLEW_RST;
         q.filt <= FILT_RST;
         q.comp <= COMP_RST;
         q.snap <= SNAP_ERASED;
         q.snap.cycles <= CYCLES_RST;
      end else begin
         q <= d;
      end
   end

   assign rsp_valid = q.rsp_valid;
   assign rsp_err = q.rsp_err;
   assign rsp_len = q.rsp_len;
   assign rsp_data = q.rsp_data;
   assign prebias_ok = q.prebias;
   assign loop_sel = q.filt;
   assign deadtime_add_ns = q.dt_add;
   assign ref_dac_corr = q.dac_corr;
   assign snap_commit = q.commit;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence loss_run;
      loss && conv_run;
   endsequence

   sequence loss_off;
      loss && !conv_run && q.off_ramp;
   endsequence

   a_vin_gate:
      assert property (!in_win(vin_slew, q.slew.vin_neg, q.slew.vin_pos)
         |=> !prebias_ok)
      else $error("pre-bias allowed with input slew out of range");

   a_vout_gate:
      assert property (!in_win(vout_slew, q.slew.vout_neg, q.slew.vout_pos)
         |=> !prebias_ok)
      else $error("pre-bias allowed with output slew out of range");

   a_filter_iout:
      assert property (cmd_wr && cmd_code == CMD_FILT
         && cmd_wdata[7:0] == 8'h01 |=> loop_sel == MCS_LOOP_IOUT && !rsp_err)
      else $error("filter byte 1 did not select current loop");

   a_snap_read:
      assert property (cmd_rd && !cmd_wr && cmd_code == CMD_SNAP
         |=> rsp_valid && rsp_len == 6'h20 && !rsp_err
         && rsp_data == $past(q.snap))
      else $error("snapshot read not a 32-byte record");

   a_snap_store:
      assert property (loss_run |=> snap_commit
         && q.snap.cycles == $past(q.snap.cycles) + 16'h0001
         && q.snap.op_time == $past(q.op_secs))
      else $error("input loss while running not stored");

   a_snap_erased:
      assert property (loss_off |=> snap_commit
         && q.snap[239:0] == SNAP_ERASED[239:0])
      else $error("off-then-loss record not all ones");

   a_temp_order:
      assert property (loss_run ##1 1'b1 |-> q.snap.temp1
         == ($past(temp_sel) ? $past(live.temp_ext) : $past(live.temp_int)))
      else $error("first temperature not from selected sensor");

   a_dt_first:
      assert property (act1 && !act2 |=> deadtime_add_ns
         == {1'b0, $past(q.comp.dt_add1)})
      else $error("first extra dead time wrong");

   a_dt_none:
      assert property (!act1 && !act2 |=> deadtime_add_ns == 9'h000)
      else $error("dead time extended with no threshold active");

   a_ref_below:
      assert property ($signed(temp_c) <= $signed(q.comp.ref_thr)
         |=> ref_dac_corr == 16'h0000)
      else $error("reference corrected below its threshold");

   a_no_spurious:
      assert property (!loss |=> !snap_commit
         && q.snap.cycles == $past(q.snap.cycles))
      else $error("snapshot counter moved without input loss");

   a_dt_both:
      assert property (act1 && act2 |=> deadtime_add_ns
         == {1'b0, $past(q.comp.dt_add1)} + {1'b0, $past(q.comp.dt_add2)})
      else $error("both extra dead times not summed");

   a_filter_refuse:
      assert property (cmd_wr && cmd_code == CMD_FILT
         && cmd_wdata[7:0] > 8'h02 |=> rsp_err && loop_sel == $past(loop_sel))
      else $error("filter byte above two was not refused");

endmodule : mcs_cfg_snapshot

// >>> mcs_dt_hyst.sv
`timescale 1ns/1ps
module mcs_dt_hyst (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Temperature and limits, signed integer degrees
   input wire logic [7:0] temp,
   input wire logic [7:0] thr,
   input wire logic [7:0] hys,
   // Extra dead time in force
   output logic active
);
   typedef struct packed {
      logic act;
   } mcs_hyst_s;

   mcs_hyst_s q;
   mcs_hyst_s d;

   always_comb begin
      d = q;
      if (!q.act && $signed(temp) < $signed(thr)) begin
         d.act = 1'b1;
      end else if (q.act && $signed(temp) > $signed(hys)) begin
         d.act = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign active = q.act;
endmodule : mcs_dt_hyst

// >>> mcs_host.sv
`timescale 1ns/1ps
module mcs_host (
   // Clock
   input wire logic clk,
   // Request
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_code,
   output logic [63:0] cmd_wdata,
   // Answer
   input wire logic rsp_valid,
   input wire logic rsp_err,
   input wire logic [5:0] rsp_len,
   input wire logic [255:0] rsp_data
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 64'h0;
   end

   // One transfer; the answer is taken the cycle after the request
   task xfer(input logic wr, input logic [7:0] code,
      input logic [63:0] wd, output logic ok, output logic err,
      output logic [5:0] len, output logic [255:0] data);
      @(negedge clk);
      cmd_wr = wr;
      cmd_rd = ~wr;
      cmd_code = code;
      cmd_wdata = wd;
      @(negedge clk);
      ok = rsp_valid;
      err = rsp_err;
      len = rsp_len;
      data = rsp_data;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      // Released lines must not keep their last value
      cmd_code = ~code;
      cmd_wdata = ~wd;
   endtask : xfer
endmodule : mcs_host

// >>> mcs_pkg.sv
package mcs_pkg;

   // Command codes seen on the management port
   localparam logic [7:0] CMD_SLEW = 8'hD4;
   localparam logic [7:0] CMD_FILT = 8'hD5;
   localparam logic [7:0] CMD_SNAP = 8'hD7;
   localparam logic [7:0] CMD_COMP = 8'hD8;

   // Block lengths in bytes
   localparam logic [5:0] LEN_SLEW = 6'h08;
   localparam logic [5:0] LEN_FILT = 6'h01;
   localparam logic [5:0] LEN_SNAP = 6'h20;
   localparam logic [5:0] LEN_COMP = 6'h08;
   localparam logic [5:0] LEN_NONE = 6'h00;

   typedef enum logic [7:0] {
      MCS_LOOP_VOUT = 8'h00,
      MCS_LOOP_IOUT = 8'h01,
      MCS_LOOP_FFWD = 8'h02
   } mcs_loop_e;

   // Slew limits, signed fixed point V/ms, MSB field first
   typedef struct packed {
      logic [15:0] vin_pos;
      logic [15:0] vin_neg;
      logic [15:0] vout_pos;
      logic [15:0] vout_neg;
   } mcs_slew_s;

   // Thermal compensation block, byte 7 first
   typedef struct packed {
      logic [7:0] dt_add2;
      logic [7:0] dt_hys2;
      logic [7:0] dt_thr2;
      logic [7:0] dt_add1;
      logic [7:0] dt_hys1;
      logic [7:0] dt_thr1;
      logic [7:0] ref_slope;
      logic [7:0] ref_thr;
   } mcs_comp_s;

   typedef struct packed {
      logic [7:0] st_mfr;
      logic [7:0] st_other;
      logic [7:0] st_comm;
      logic [7:0] st_temp;
      logic [7:0] st_vin;
      logic [7:0] st_iout;
      logic [7:0] st_vout;
      logic [7:0] st_byte;
      logic [15:0] st_word;
   } mcs_status_s;

   // Snapshot record, 32 bytes, counter in the top field
   typedef struct packed {
      logic [15:0] cycles;
      mcs_status_s status;
      logic [15:0] op_time;
      logic [15:0] temp2;
      logic [15:0] temp1;
      logic [15:0] iload;
      logic [15:0] vout;
      logic [15:0] vin;
      logic [15:0] duty_old;
      logic [15:0] iload_old;
      logic [15:0] vout_old;
      logic [15:0] vin_old;
   } mcs_snap_s;

   // Live telemetry from the converter core
   typedef struct packed {
      mcs_status_s status;
      logic [15:0] temp_int;
      logic [15:0] temp_ext;
      logic [15:0] iload;
      logic [15:0] vout;
      logic [15:0] vin;
      logic [15:0] duty;
   } mcs_live_s;

   localparam mcs_slew_s SLEW_RST = '{
      vin_pos: 16'h7FFF, vin_neg: 16'h8000,
      vout_pos: 16'h7FFF, vout_neg: 16'h8000};
   localparam mcs_loop_e FILT_RST = MCS_LOOP_VOUT;
   localparam mcs_comp_s COMP_RST = '{default: 8'h00};
   localparam logic [255:0] SNAP_ERASED = {256{1'b1}};
   localparam logic [15:0] CYCLES_RST = 16'h0000;

   // One second of operating time
   localparam longint SEC_NS = 1000000000;
   localparam longint CLK_NS = 10;
   localparam int unsigned SEC_CYCLES_DEF = int'(SEC_NS / CLK_NS);

endpackage : mcs_pkg

// >>> mcs_sync2.sv
`timescale 1ns/1ps
module mcs_sync2 (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Level in and out
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
   } mcs_sync_s;

   mcs_sync_s q;
   mcs_sync_s d;

   always_comb begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule : mcs_sync2

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import mcs_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_wr, cmd_rd, rsp_valid, rsp_err, snap_commit, prebias_ok;
   logic [7:0] cmd_code;
   logic [63:0] cmd_wdata;
   logic [5:0] rsp_len;
   logic [255:0] rsp_data;
   logic cfg_load = 1'b0;
   mcs_comp_s cfg_comp = '0;
   logic conv_run = 1'b0;
   logic vin_pin = 1'b0;
   logic temp_sel = 1'b1;
   logic [15:0] vin_slew = 16'h0000;
   logic [15:0] vout_slew = 16'h0000;
   logic [7:0] temp_c = 8'h32;
   mcs_live_s live = {80'h1122A1B2C3D4E5F60718, 16'h0019, 16'h0023,
      16'h0050, 16'h0C00, 16'h0030, 16'h0040};
   mcs_loop_e loop_sel;
   logic [8:0] dt_add;
   logic [15:0] ref_corr;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   mcs_host host_u (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_err(rsp_err), .rsp_len(rsp_len), .rsp_data(rsp_data));

   mcs_cfg_snapshot #(.SEC_CYCLES(20)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
      .rsp_len(rsp_len), .rsp_data(rsp_data), .cfg_load(cfg_load),
      .cfg_comp(cfg_comp), .conv_run(conv_run), .vin_present_pin(vin_pin),
      .temp_sel(temp_sel), .vin_slew(vin_slew), .vout_slew(vout_slew),
      .temp_c(temp_c), .live(live), .prebias_ok(prebias_ok),
      .loop_sel(loop_sel), .deadtime_add_ns(dt_add),
      .ref_dac_corr(ref_corr), .snap_commit(snap_commit));

   task check(input logic [263:0] seen, input logic [263:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("Error at %0t: run too long", $time);
         complete_run;
      end
   end

   task rd(input logic [7:0] c, output logic [5:0] l,
      output logic [255:0] d);
      logic ok, e;
      host_u.xfer(1'b0, c, 64'h0, ok, e, l, d);
      check({ok, e}, 2'h2);
   endtask : rd

   task wr(input logic [7:0] c, input logic [63:0] w, input logic xe);
      logic ok, e;
      logic [5:0] l;
      logic [255:0] d;
      host_u.xfer(1'b1, c, w, ok, e, l, d);
      check({ok, e}, {1'b1, xe});
   endtask : wr

   task wait_commit(output int n);
      n = 0;
      repeat (8) begin
         @(negedge clk);
         if (snap_commit !== 1'b0) n++;
      end
   endtask : wait_commit

   task test_reset;
      logic [5:0] l;
      logic [255:0] d;
      rd(CMD_SLEW, l, d);
      check({l, d}, {LEN_SLEW, 192'h0, SLEW_RST});
      rd(CMD_FILT, l, d);
      check({l, d}, {LEN_FILT, 248'h0, FILT_RST});
      rd(CMD_SNAP, l, d);
      check({l, d}, {LEN_SNAP, CYCLES_RST, SNAP_ERASED[239:0]});
      rd(CMD_COMP, l, d);
      check({l, d}, {LEN_COMP, 192'h0, COMP_RST});
      $display("test reset done");
   endtask : test_reset

   task test_slew;
      logic [5:0] l;
      logic [255:0] d;
      logic [32:0] cs [6] = '{{16'h0100, 16'h0080, 1'b1},
         {16'h0101, 16'h0000, 1'b0}, {16'hFF00, 16'hFF80, 1'b1},
         {16'hFEFF, 16'h0000, 1'b0}, {16'h0000, 16'h0081, 1'b0},
         {16'h0000, 16'hFF7F, 1'b0}};
      wr(CMD_SLEW, 64'h0100FF000080FF80, 1'b0);
      rd(CMD_SLEW, l, d);
      check(d, {192'h0, 64'h0100FF000080FF80});
      foreach (cs[i]) begin
         @(negedge clk);
         vin_slew = cs[i][32:17];
         vout_slew = cs[i][16:1];
         repeat (2) @(negedge clk);
         check(prebias_ok, cs[i][0]);
      end
      $display("test slew done");
   endtask : test_slew

   task test_cmd;
      logic ok, e;
      logic [5:0] l;
      logic [255:0] d;
      for (int i = 0; i < 4; i++) begin
         wr(CMD_FILT, 64'(i), i == 3);
         check(loop_sel, (i == 3) ? 2 : i);
      end
      wr(CMD_SNAP, '1, 1'b1);
      wr(CMD_COMP, '1, 1'b1);
      host_u.xfer(1'b0, 8'hD6, 64'h0, ok, e, l, d);
      check({ok, e, l, d}, {2'h3, 262'h0});
      $display("test command done");
   endtask : test_cmd

   task test_comp;
      logic [5:0] l;
      logic [255:0] d;
      logic [32:0] cs [9] = '{{8'h32, 9'h000, 16'h0001},
         {8'h05, 9'h01E, 16'h0000}, {8'h0F, 9'h01E, 16'h0000},
         {8'h15, 9'h000, 16'h0000}, {8'hF6, 9'h082, 16'h0000},
         {8'h01, 9'h01E, 16'h0000}, {8'hFF, 9'h01E, 16'h0000},
         {8'h78, 9'h000, 16'h000F}, {8'h28, 9'h000, 16'h0000}};
      @(negedge clk);
      cfg_comp = 64'h6400FB1E140A3328;
      cfg_load = 1'b1;
      @(negedge clk);
      cfg_load = 1'b0;
      rd(CMD_COMP, l, d);
      check({l, d}, {LEN_COMP, 192'h0, 64'h6400FB1E140A3328});
      foreach (cs[i]) begin
         @(negedge clk);
         temp_c = cs[i][32:25];
         repeat (3) @(negedge clk);
         check(dt_add, cs[i][24:16]);
         check(ref_corr, cs[i][15:0]);
      end
      $display("test compensation done");
   endtask : test_comp

   task test_snap;
      int n;
      logic [5:0] l;
      logic [255:0] d;
      mcs_snap_s x;
      @(negedge clk);
      vin_pin = 1'b1;
      repeat (10) @(negedge clk);
      vin_pin = 1'b0;
      wait_commit(n);
      check(n, 0);
      vin_pin = 1'b1;
      repeat (5) @(negedge clk);
      conv_run = 1'b1;
      repeat (100) @(negedge clk);
      vin_pin = 1'b0;
      wait_commit(n);
      check(n, 1);
      conv_run = 1'b0;
      rd(CMD_SNAP, l, d);
      check(d[159:144] >= 4 && d[159:144] <= 6, 1'b1);
      x = {16'h0001, live.status, d[159:144], live.temp_int, live.temp_ext,
         live.iload, live.vout, live.vin, live.duty, live.iload,
         live.vout, live.vin};
      check(d, x);
      vin_pin = 1'b1;
      repeat (5) @(negedge clk);
      conv_run = 1'b1;
      repeat (30) @(negedge clk);
      conv_run = 1'b0;
      repeat (10) @(negedge clk);
      vin_pin = 1'b0;
      wait_commit(n);
      check(n, 1);
      rd(CMD_SNAP, l, d);
      check(d, {16'h0002, SNAP_ERASED[239:0]});
      temp_sel = 1'b0;
      vin_pin = 1'b1;
      repeat (5) @(negedge clk);
      conv_run = 1'b1;
      repeat (30) @(negedge clk);
      vin_pin = 1'b0;
      wait_commit(n);
      check(n, 1);
      conv_run = 1'b0;
      rd(CMD_SNAP, l, d);
      check(d[255:240], 16'h0003);
      check(d[143:112], {live.temp_ext, live.temp_int});
      check(d[63:0], {live.duty, live.iload, live.vout,
         live.vin});
      $display("test snapshot done");
   endtask : test_snap

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      test_reset;
      test_slew;
      test_cmd;
      test_comp;
      test_snap;
      complete_run;
   end
endmodule : tb
